// file: hdl/hpx_xlate.v
`timescale 1ns/10ps
`include "hpx_defines.vh"
// Operation
// - Process tag register holds a 20-bit process identifier.
// - Walk select 0 means hashed mode; process and partition tags are held but not used in translation.
// - Hashed mode supports only table use 0, 32 segment entries, process tag ignored.
// - Effective address 64 bits, virtual address 68 bits, real address 51 bits.
// - Segment miss searches in-memory table and caches the found entry.
// - Four bolted segment entries are never evicted by the replacement policy.
// - Duplicate or overlapping segment tags may raise a multi-hit machine check.
// - Segment-find writes zero to condition field 0 when table use is 1.
// - Invalidate-all with reserved hint 101 behaves as hint 111.
// - Segments 256 MB and 1 TB; pages 4K, 64K, 16M, 16G, one entry each.
// - Remapping a page size without invalidation may raise a parity machine check.
// - Mixed sizes only 4K/64K, 4K/16M and 64K/16M.
// - Segment code 000 is 4K base, 101 is 64K base, unknown codes as 000.
// - Code 110 with a 256 MB segment is treated as 000.
// - Hashed mode uses 256 sets of 4 ways, one hash for all accesses.
// - Set index hash for 256 MB segments per page size.
// - Set index hash for 1 TB segments per page size.
// - Global invalidate page codes must be 000, 101 or 100, else machine check.
// - Operand segment size 00 is 256 MB, 01 is 1 TB; 16G on 256 MB illegal.
// - Half-TLB mode uses only 128 sets for page entries.
module hpx_xlate (
  // Clock and reset.
  input  wire        CLOCK,
  input  wire        RST,
  // Register port.
  input  wire [7:0]  ADDR,
  input  wire [31:0] WDATA,
  input  wire        WE,
  input  wire        RE,
  output reg  [31:0] RDATA,
  // Segment table search port.
  output reg         ST_REQ,
  output reg  [35:0] ST_EFF_SEGMENT_TAG,
  input  wire        ST_DONE,
  input  wire        ST_FOUND,
  input  wire [49:0] ST_VIRT_SEGMENT_TAG,
  input  wire        ST_SEG1T,
  input  wire [2:0]  ST_PCODE,
  // Machine check level.
  output reg         MACHINE_CHECK
);

  localparam S_IDLE = 2'h0;
  localparam S_LOOK = 2'h1;
  localparam S_WALK = 2'h2;

  // ==========================================================
  // Functions
  // ==========================================================
  // Base page size from segment code: 0 4K, 1 64K, 2 16M, 3 16G.
  function [1:0] base_size;
    input [2:0] pc;
    input       seg1t;
    begin
      case (pc)
        `HPX_PC_64K: base_size = 2'h1;
        `HPX_PC_16M: base_size = 2'h2;
        `HPX_PC_16G: base_size = seg1t ? 2'h3 : 2'h0;
        default:     base_size = 2'h0;
      endcase
    end
  endfunction

  // Set index; doc bit i of EA is ea[63-i], of VIRT_SEGMENT_TAG is virt_segment_tag[49-i].
  function [7:0] set_index;
    input [49:0] vs;
    input [63:0] ea;
    input        seg1t;
    input [1:0]  ps;
    reg   [3:0]  t;
    begin
      t = seg1t ? vs[15:12] : vs[3:0];
      case (ps)
        2'h0:    set_index = {t ^ ea[19:16], ea[15:12]};
        2'h1:    set_index = {t ^ ea[23:20], ea[19:16]};
        2'h2:    set_index = seg1t ? {t ^ ea[31:28], ea[27:24]} : {t, ea[27:24]};
        default: set_index = {t ^ ea[38:35], ea[37:34]};
      endcase
    end
  endfunction

  // Segment tag compare: 1 TB segments compare EA(0:23) only.
  function seg_match;
    input [35:0] a;
    input [35:0] b;
    input        seg1t;
    begin
      seg_match = seg1t ? (a[35:12] == b[35:12]) : (a == b);
    end
  endfunction

  // ==========================================================
  // Registers
  // ==========================================================
  reg [19:0] process_tag_reg;
  reg [31:0] partition_tag_reg;
  reg        process_table_use;
  reg        tree_walk_sel;
  reg [2:0]  rma_class_field;
  reg [31:0] core_tuning_reg;
  reg [63:0] ea;
  reg [1:0]  size_selector_bits;
  reg [26:0] rpn;
  reg [49:0] virt_segment_tag_wr;
  reg        seg1t_wr;
  reg [2:0]  pcode_wr;
  reg [1:0]  bolt_idx;
  reg [17:0] tlbi_ops;
  reg [9:0]  status;
  reg [3:0]  cr0;
  reg [2:0]  eff_hint;
  reg [7:0]  set_idx;
  reg [67:0] va;
  reg [50:0] ra;
  reg [1:0]  state;
  reg        is_find;
  reg        inv_tlb_seen;
  reg        inv_seg_seen;

  // Segment buffer.
  reg [31:0] sv;
  reg [31:0] used;
  reg [35:0] s_eff_segment_tag [0:31];
  reg [49:0] s_virt_segment_tag [0:31];
  reg [31:0] s_seg1t;
  reg [2:0]  s_pcode [0:31];

  // Last page size seen per TLB set.
  reg [255:0] tv;
  reg [1:0]   tsize [0:255];

  wire hashed = ~tree_walk_sel;
  wire half   = core_tuning_reg[`HPX_TUNE_HALF];
  wire cmd_wr = WE && (ADDR == `HPX_A_CMD);
  wire [3:0] op = WDATA[3:0];

  // ==========================================================
  // Segment buffer search and victim choice
  // ==========================================================
  reg [4:0] hit_idx;
  reg [5:0] hit_cnt;
  reg [4:0] victim;
  reg       victim_found;
  reg       all_used;
  integer   i;

  always @* begin
    hit_idx = 5'h00;
    hit_cnt = 6'h00;
    victim = 5'h04;
    victim_found = 1'b0;
    all_used = 1'b1;
    for (i = `HPX_SEG_ENTRIES - 1; i >= 0; i = i - 1) begin
      if (sv[i] && seg_match(s_eff_segment_tag[i], ea[63:28], s_seg1t[i])) begin
        hit_idx = i[4:0];
        hit_cnt = hit_cnt + 6'h01;
      end
    end
    // Bolted slots 0..3 never take part in replacement.
    for (i = `HPX_SEG_ENTRIES - 1; i >= `HPX_BOLTED; i = i - 1) begin
      if (!sv[i] || !used[i]) begin
        victim = i[4:0];
        victim_found = 1'b1;
      end
      if (sv[i] && !used[i])
        all_used = 1'b0;
    end
  end

  // ==========================================================
  // Lookup result
  // ==========================================================
  wire [49:0] h_virt_segment_tag  = s_virt_segment_tag[hit_idx];
  wire        h_seg1t = s_seg1t[hit_idx];
  wire [1:0]  h_base  = base_size(s_pcode[hit_idx], h_seg1t);
  wire [1:0]  h_act   = size_selector_bits;
  wire        mix_ok  = (h_act == h_base) ||
                        (h_base == 2'h0 && h_act != 2'h3) ||
                        (h_base == 2'h1 && h_act == 2'h2);
  wire        act_ok  = mix_ok && (h_seg1t || h_act != 2'h3);
  wire [7:0]  h_set   = set_index(h_virt_segment_tag, ea, h_seg1t, h_act);
  wire [7:0]  h_setm  = half ? {1'b0, h_set[6:0]} : h_set;
  // 78-bit virtual address, top ten bits dropped.
  wire [77:0] va_full = h_seg1t ? {h_virt_segment_tag[49:12], ea[39:0]} : {h_virt_segment_tag, ea[27:0]};
  reg  [63:0] off_mask;

  always @* begin
    case (h_act)
      2'h0:    off_mask = 64'h0000000000000FFF;
      2'h1:    off_mask = 64'h000000000000FFFF;
      2'h2:    off_mask = 64'h0000000000FFFFFF;
      default: off_mask = 64'h00000003FFFFFFFF;
    endcase
  end

  wire [63:0] ra_full = ({25'h0000000, rpn, 12'h000} & ~off_mask) | (ea & off_mask);

  // ==========================================================
  // Invalidate operand check
  // ==========================================================
  wire [1:0] t_ric = tlbi_ops[1:0];
  wire [1:0] t_is  = tlbi_ops[3:2];
  wire       t_l   = tlbi_ops[4];
  wire [2:0] t_ap  = tlbi_ops[7:5];
  wire [1:0] t_ss  = tlbi_ops[9:8];
  wire [7:0] t_lp  = tlbi_ops[17:10];
  wire       t_ap_ok = (t_ap == `HPX_PC_4K) || (t_ap == `HPX_PC_64K) || (t_ap == `HPX_PC_16M);
  wire       t_lp_ok = (t_lp == 8'h00) || (t_lp[3:0] == 4'h1) || (t_lp == 8'h08) ||
                       (t_lp == 8'h03 && t_ss == 2'h1);
  wire       t_ss_ok = (t_ss == 2'h0) || (t_ss == 2'h1);
  wire       t_ric02 = (t_ric == 2'h0) || (t_ric == 2'h2);
  wire       t_bad   = t_ric02 && !(t_ss_ok && (t_l ? t_lp_ok : t_ap_ok));

  // ==========================================================
  // Control
  // ==========================================================
  always @(posedge CLOCK) begin
    if (RST) begin
      process_tag_reg <= 20'h00000;
      partition_tag_reg <= 32'h00000000;
      process_table_use <= 1'b0;
      tree_walk_sel <= 1'b0;
      rma_class_field <= 3'h0;
      core_tuning_reg <= 32'h00000000;
      ea <= 64'h0000000000000000;
      size_selector_bits <= 2'h0;
      rpn <= 27'h0000000;
      virt_segment_tag_wr <= 50'h0;
      seg1t_wr <= 1'b0;
      pcode_wr <= 3'h0;
      bolt_idx <= 2'h0;
      tlbi_ops <= 18'h00000;
      status <= 10'h000;
      cr0 <= 4'h0;
      eff_hint <= 3'h0;
      set_idx <= 8'h00;
      va <= 68'h0;
      ra <= 51'h0;
      state <= S_IDLE;
      is_find <= 1'b0;
      inv_tlb_seen <= 1'b0;
      inv_seg_seen <= 1'b0;
      sv <= 32'h00000000;
      used <= 32'h00000000;
      s_seg1t <= 32'h00000000;
      tv <= {256{1'b0}};
      ST_REQ <= 1'b0;
      ST_EFF_SEGMENT_TAG <= 36'h000000000;
      MACHINE_CHECK <= 1'b0;
    end else begin
      MACHINE_CHECK <= status[`HPX_ST_MC_MULTI] | status[`HPX_ST_MC_SIZE] | status[`HPX_ST_MC_TLBI];
      if (WE) begin
        case (ADDR)
          `HPX_A_PROC_TAG:  process_tag_reg <= WDATA[19:0];
          `HPX_A_PART_TAG:  partition_tag_reg <= WDATA;
          `HPX_A_PART_CTL: begin
            process_table_use <= WDATA[`HPX_CTL_PTU];
            tree_walk_sel <= WDATA[`HPX_CTL_TWS];
            rma_class_field <= WDATA[4:2];
          end
          `HPX_A_CORE_TUNE: core_tuning_reg <= WDATA;
          `HPX_A_EA_HI:     ea[63:32] <= WDATA;
          `HPX_A_EA_LO:     ea[31:0] <= WDATA;
          `HPX_A_PTE: begin
            size_selector_bits <= WDATA[1:0];
            rpn <= WDATA[28:2];
          end
          `HPX_A_VIRT_SEGMENT_TAG_HI:   virt_segment_tag_wr[49:32] <= WDATA[17:0];
          `HPX_A_VIRT_SEGMENT_TAG_LO:   virt_segment_tag_wr[31:0] <= WDATA;
          `HPX_A_SEG_ATTR: begin
            seg1t_wr <= WDATA[0];
            pcode_wr <= WDATA[3:1];
            bolt_idx <= WDATA[5:4];
          end
          `HPX_A_TLBI:      tlbi_ops <= WDATA[17:0];
          // Write one to clear; a same-cycle set below wins.
          `HPX_A_STATUS:    status[9:1] <= status[9:1] & ~WDATA[9:1];
          default: ;
        endcase
      end
      case (state)
        S_IDLE: begin
          if (cmd_wr) begin
            case (op)
              `HPX_OP_LOOKUP, `HPX_OP_SEGFIND: begin
                is_find <= (op == `HPX_OP_SEGFIND);
                status[`HPX_ST_HIT] <= 1'b0;
                if (op == `HPX_OP_LOOKUP && (!hashed || process_table_use))
                  status[`HPX_ST_REFUSED] <= 1'b1;
                else begin
                  status[`HPX_ST_BUSY] <= 1'b1;
                  state <= S_LOOK;
                end
              end
              `HPX_OP_SLBIA: begin
                eff_hint <= (WDATA[6:4] == `HPX_HINT_RSVD) ? `HPX_HINT_ALL : WDATA[6:4];
                // Hint 000 also drops bolted slots; every other hint keeps them.
                sv <= (WDATA[6:4] == 3'h0) ? 32'h00000000 : (sv & 32'h0000000F);
                used <= 32'h00000000;
                inv_seg_seen <= 1'b1;
              end
              `HPX_OP_SLBWR: begin
                sv[bolt_idx] <= 1'b1;
                s_eff_segment_tag[bolt_idx] <= ea[63:28];
                s_virt_segment_tag[bolt_idx] <= virt_segment_tag_wr;
                s_seg1t[bolt_idx] <= seg1t_wr;
                s_pcode[bolt_idx] <= pcode_wr;
              end
              `HPX_OP_TLBIE: begin
                if (t_bad)
                  status[`HPX_ST_MC_TLBI] <= 1'b1;
                else if (t_ric == 2'h2 && t_is == 2'h3) begin
                  tv <= {256{1'b0}};
                  inv_tlb_seen <= 1'b1;
                end
              end
              default: ;
            endcase
          end
        end
        S_LOOK: begin
          if (hit_cnt > 6'h01) begin
            status[`HPX_ST_MC_MULTI] <= 1'b1;
            status[`HPX_ST_BUSY] <= 1'b0;
            state <= S_IDLE;
          end else if (hit_cnt == 6'h01) begin
            used[hit_idx] <= 1'b1;
            status[`HPX_ST_HIT] <= 1'b1;
            status[`HPX_ST_BUSY] <= 1'b0;
            state <= S_IDLE;
            if (is_find)
              cr0 <= process_table_use ? 4'h0 : 4'h2;
            else if (!act_ok)
              status[`HPX_ST_MIX_ERR] <= 1'b1;
            else begin
              set_idx <= h_setm;
              va <= va_full[67:0];
              ra <= ra_full[50:0];
              tsize[h_setm] <= h_act;
              tv[h_setm] <= 1'b1;
              if (tv[h_setm] && tsize[h_setm] != h_act) begin
                status[`HPX_ST_MC_SIZE] <= 1'b1;
                inv_tlb_seen <= 1'b0;
                inv_seg_seen <= 1'b0;
              end
            end
          end else if (is_find) begin
            cr0 <= 4'h0;
            status[`HPX_ST_BUSY] <= 1'b0;
            state <= S_IDLE;
          end else begin
            ST_REQ <= 1'b1;
            ST_EFF_SEGMENT_TAG <= ea[63:28];
            state <= S_WALK;
          end
        end
        S_WALK: begin
          if (ST_DONE) begin
            ST_REQ <= 1'b0;
            if (ST_FOUND) begin
              sv[victim] <= 1'b1;
              used[victim] <= 1'b0;
              if (!victim_found || all_used)
                used[31:`HPX_BOLTED] <= {(`HPX_SEG_ENTRIES - `HPX_BOLTED){1'b0}};
              s_eff_segment_tag[victim] <= ST_EFF_SEGMENT_TAG;
              s_virt_segment_tag[victim] <= ST_VIRT_SEGMENT_TAG;
              s_seg1t[victim] <= ST_SEG1T;
              s_pcode[victim] <= ST_PCODE;
              state <= S_LOOK;
            end else begin
              status[`HPX_ST_FAULT] <= 1'b1;
              status[`HPX_ST_BUSY] <= 1'b0;
              state <= S_IDLE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
      // Whole TLB flushed and segment buffer invalidated with any hint, bolted slots kept or not: size hazard is gone.
      if (inv_tlb_seen && inv_seg_seen && state == S_IDLE && !(WE && ADDR == `HPX_A_CMD)) begin
        status[`HPX_ST_MC_SIZE] <= 1'b0;
        inv_tlb_seen <= 1'b0;
        inv_seg_seen <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read path
  // ==========================================================
  always @(posedge CLOCK) begin
    if (RST)
      RDATA <= 32'h00000000;
    else if (RE) begin
      case (ADDR)
        `HPX_A_PROC_TAG:  RDATA <= {12'h000, process_tag_reg};
        `HPX_A_PART_TAG:  RDATA <= partition_tag_reg;
        `HPX_A_PART_CTL:  RDATA <= {27'h0000000, rma_class_field, tree_walk_sel, process_table_use};
        `HPX_A_CORE_TUNE: RDATA <= core_tuning_reg;
        `HPX_A_EA_HI:     RDATA <= ea[63:32];
        `HPX_A_EA_LO:     RDATA <= ea[31:0];
        `HPX_A_TLBI:      RDATA <= {14'h0000, tlbi_ops};
        `HPX_A_STATUS:    RDATA <= {15'h0000, eff_hint, cr0, state != S_IDLE, status[8:0]};
        `HPX_A_SET_IDX:   RDATA <= {24'h000000, set_idx};
        `HPX_A_VA_HI:     RDATA <= {28'h0000000, va[67:64]};
        `HPX_A_VA_MID:    RDATA <= va[63:32];
        `HPX_A_VA_LO:     RDATA <= va[31:0];
        `HPX_A_RA_HI:     RDATA <= {13'h0000, ra[50:32]};
        `HPX_A_RA_LO:     RDATA <= ra[31:0];
        default:          RDATA <= 32'h00000000;
      endcase
    end else
      RDATA <= 32'h00000000;
  end

endmodule // hpx_xlate

// file: inc/hpx_defines.vh
`ifndef HPX_DEFINES_VH
`define HPX_DEFINES_VH
// Register word addresses.
`define HPX_A_PROC_TAG  8'h00
`define HPX_A_PART_TAG  8'h01
`define HPX_A_PART_CTL  8'h02
`define HPX_A_CORE_TUNE 8'h03
`define HPX_A_EA_HI     8'h04
`define HPX_A_EA_LO     8'h05
`define HPX_A_PTE       8'h06
`define HPX_A_VIRT_SEGMENT_TAG_HI   8'h07
`define HPX_A_VIRT_SEGMENT_TAG_LO   8'h08
`define HPX_A_SEG_ATTR  8'h09
`define HPX_A_TLBI      8'h0A
`define HPX_A_CMD       8'h0B
`define HPX_A_STATUS    8'h10
`define HPX_A_SET_IDX   8'h11
`define HPX_A_VA_HI     8'h12
`define HPX_A_VA_MID    8'h13
`define HPX_A_VA_LO     8'h14
`define HPX_A_RA_HI     8'h15
`define HPX_A_RA_LO     8'h16
// Field positions.
`define HPX_PROC_TAG_W  20
`define HPX_CTL_PTU     0
`define HPX_CTL_TWS     1
`define HPX_TUNE_HALF   8
`define HPX_ST_BUSY     0
`define HPX_ST_HIT      1
`define HPX_ST_FAULT    2
`define HPX_ST_MC_MULTI 3
`define HPX_ST_MC_SIZE  4
`define HPX_ST_MC_TLBI  5
`define HPX_ST_MIX_ERR  6
`define HPX_ST_REFUSED  7
// Commands, CMD[3:0].
`define HPX_OP_LOOKUP   4'h1
`define HPX_OP_SEGFIND  4'h2
`define HPX_OP_SLBIA    4'h3
`define HPX_OP_SLBWR    4'h4
`define HPX_OP_TLBIE    4'h5
// Sizes.
`define HPX_SEG_ENTRIES 32
`define HPX_BOLTED      4
`define HPX_TLB_SETS    256
`define HPX_VA_W        68
`define HPX_RA_W        51
// Segment page-size codes.
`define HPX_PC_4K       3'h0
`define HPX_PC_16M      3'h4
`define HPX_PC_64K      3'h5
`define HPX_PC_16G      3'h6
`define HPX_HINT_RSVD   3'h5
`define HPX_HINT_ALL    3'h7
`endif

// file: testbench/hpx_xlate_checker.sv
`timescale 1ns/10ps
`include "hpx_defines.vh"
// ==========
// Port checker for the translation block.
module hpx_xlate_chk (
  // Clock and reset.
  input wire        CLOCK,
  input wire        RST,
  // Register port.
  input wire [7:0]  ADDR,
  input wire        WE,
  input wire [31:0] WDATA,
  input wire        RE,
  input wire [31:0] RDATA,
  // Segment table search and machine check.
  input wire        ST_REQ,
  input wire [35:0] ST_EFF_SEGMENT_TAG,
  input wire        ST_DONE,
  input wire        MACHINE_CHECK
);
  reg half;
  // The set index width depends on the tuning bit, so the checker keeps its own copy.
  always @(posedge CLOCK) begin
    if (RST)
      half <= 1'b0;
    else if (WE && ADDR == `HPX_A_CORE_TUNE)
      half <= WDATA[`HPX_TUNE_HALF];
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  property p_rdata_idle; !$past(RE) |-> RDATA == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  property p_proc_w; RE && ADDR == `HPX_A_PROC_TAG |=> RDATA[31:20] == 12'h0; endproperty
  a_proc_w: assert property (p_proc_w) else $error("process tag too wide");
  property p_va_w; RE && ADDR == `HPX_A_VA_HI |=> RDATA[31:4] == 28'h0; endproperty
  a_va_w: assert property (p_va_w) else $error("virtual address too wide");
  property p_ra_w; RE && ADDR == `HPX_A_RA_HI |=> RDATA[31:19] == 13'h0; endproperty
  a_ra_w: assert property (p_ra_w) else $error("real address too wide");
  property p_idx_w; RE && ADDR == `HPX_A_SET_IDX |=> RDATA[31:8] == 24'h0; endproperty
  a_idx_w: assert property (p_idx_w) else $error("set index too wide");
  property p_idx_half; RE && ADDR == `HPX_A_SET_IDX && half |=> !RDATA[7]; endproperty
  a_idx_half: assert property (p_idx_half) else $error("half mode index too wide");
  property p_st_hold; ST_REQ && !ST_DONE |=> ST_REQ && $stable(ST_EFF_SEGMENT_TAG); endproperty
  a_st_hold: assert property (p_st_hold) else $error("search request dropped");
  property p_st_drop; ST_REQ && ST_DONE |=> !ST_REQ; endproperty
  a_st_drop: assert property (p_st_drop) else $error("search request not released");
  property p_mc; $past(RE) && $past(ADDR) == `HPX_A_STATUS |-> MACHINE_CHECK == (|RDATA[5:3]); endproperty
  a_mc: assert property (p_mc) else $error("machine check differs from status");
endmodule // hpx_xlate_chk
bind hpx_xlate hpx_xlate_chk u_chk (
  .CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WE(WE), .WDATA(WDATA), .RE(RE), .RDATA(RDATA),
  .ST_REQ(ST_REQ), .ST_EFF_SEGMENT_TAG(ST_EFF_SEGMENT_TAG), .ST_DONE(ST_DONE), .MACHINE_CHECK(MACHINE_CHECK)
);

// file: testbench/tb_hpx_xlate.sv
`timescale 1ns/10ps
`include "hpx_defines.vh"
// ==========
// Register-level testbench of the translation block.
module tb_hpx_xlate;
  // Case byte: [7] pair refused, [6] 1 TB segment, [5:3] segment page code, [1:0] actual size.
  localparam [119:0] cases = {8'h00, 8'h01, 8'h02, 8'h29, 8'h2A, 8'hA8, 8'h30, 8'h18,
                              8'h40, 8'h69, 8'h62, 8'h73, 8'hB3, 8'hC3, 8'h22};
  localparam [63:0]  ea    = 64'h0123_4567_89AB_CDEF;
  localparam [63:0]  ea2   = 64'h0123_4567_8000_0ABC;
  localparam [49:0]  vs    = 50'h2_A5C3_96E1_7B4D;
  localparam [26:0]  rpn   = 27'h012_3456;
  reg         clock = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  addr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg         we = 1'b0;
  reg         re = 1'b0;
  reg         st_done = 1'b0;
  reg         st_found = 1'b0;
  reg  [49:0] st_virt_segment_tag = 50'h0;
  reg         st_seg1t = 1'b0;
  reg  [2:0]  st_pcode = 3'h0;
  wire [31:0] rdata;
  wire        st_req;
  wire [35:0] st_eff_segment_tag;
  wire        mcheck;
  reg  [35:0] eff_segment_tag_seen = 36'h0;
  reg         tab_found = 1'b1;
  reg  [63:0] e2;
  reg  [31:0] d;
  reg  [31:0] x;
  reg  [7:0]  c;
  integer     n_mismatch = 0;
  integer     n_compared = 0;
  integer     n_walk = 0;
  integer     wcnt = 0;
  integer     i, j, k;
  always #2.5 clock = ~clock;
  hpx_xlate dut (
    .CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata), .WE(we), .RE(re), .RDATA(rdata),
    .ST_REQ(st_req), .ST_EFF_SEGMENT_TAG(st_eff_segment_tag), .ST_DONE(st_done), .ST_FOUND(st_found),
    .ST_VIRT_SEGMENT_TAG(st_virt_segment_tag), .ST_SEG1T(st_seg1t), .ST_PCODE(st_pcode), .MACHINE_CHECK(mcheck)
  );
  // ==========
  // Segment table in memory: answers four cycles after a request. Outside the answer the
  // lines carry the inverse of the entry, so a design that samples late sees garbage.
  always @(posedge clock) begin
    st_done  <= 1'b0;
    st_found <= ~tab_found;
    st_virt_segment_tag  <= ~vs;
    st_seg1t <= 1'b1;
    st_pcode <= 3'h7;
    if (st_req && !st_done) begin
      wcnt <= wcnt + 1;
      if (wcnt == 0) begin
        eff_segment_tag_seen <= st_eff_segment_tag;
        n_walk    <= n_walk + 1;
      end
      if (wcnt == 3) begin
        wcnt     <= 0;
        st_done  <= 1'b1;
        st_found <= tab_found;
        st_virt_segment_tag  <= vs;
        st_seg1t <= 1'b0;
        st_pcode <= 3'h0;
      end
    end
  end
  // ==========
  // Access tasks.
  task chk(input string nm, input [63:0] seen, input [63:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clock);
      addr  <= a;
      wdata <= v;
      we    <= 1'b1;
      @(posedge clock);
      we    <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] v);
    begin
      @(posedge clock);
      addr <= a;
      re   <= 1'b1;
      @(posedge clock);
      re   <= 1'b0;
      #1 v = rdata;
    end
  endtask
  // Leaves the final status word in d.
  task cmd(input [31:0] op);
    begin
      wr(`HPX_A_CMD, op);
      repeat (2) @(posedge clock);
      rd(`HPX_A_STATUS, d);
      j = 0;
      while (d[0] !== 1'b0 && j < 40) begin
        rd(`HPX_A_STATUS, d);
        j = j + 1;
      end
      chk("busy", d[0], 1'b0);
    end
  endtask
  // Full invalidate, which also clears the page size history, then clears status.
  task flush;
    begin
      wr(`HPX_A_TLBI, 32'h0000_000E);
      cmd(32'h5);
      cmd(32'h73);
      wr(`HPX_A_STATUS, 32'h0000_03FE);
    end
  endtask
  task look(input [63:0] e, input [5:0] at, input [1:0] ps, input bolt);
    begin
      wr(`HPX_A_EA_HI, e[63:32]);
      wr(`HPX_A_EA_LO, e[31:0]);
      wr(`HPX_A_VIRT_SEGMENT_TAG_HI, {14'h0, vs[49:32]});
      wr(`HPX_A_VIRT_SEGMENT_TAG_LO, vs[31:0]);
      wr(`HPX_A_SEG_ATTR, {26'h0, at});
      wr(`HPX_A_PTE, {3'h0, rpn, ps});
      if (bolt)
        cmd(32'h4);
      cmd(32'h1);
    end
  endtask
  task tlbi(input [31:0] w, input exp);
    begin
      wr(`HPX_A_STATUS, 32'h0000_03FE);
      wr(`HPX_A_TLBI, w);
      cmd(32'h5);
      chk("invalidate check", d[5], exp);
    end
  endtask
  function [7:0] hidx(input [63:0] e, input s1, input [1:0] ps);
    reg [3:0] t;
    begin
      t = s1 ? vs[15:12] : vs[3:0];
      case (ps)
        2'h0: hidx = {t ^ e[19:16], e[15:12]};
        2'h1: hidx = {t ^ e[23:20], e[19:16]};
        2'h2: hidx = s1 ? {t ^ e[31:28], e[27:24]} : {t, e[27:24]};
        default: hidx = {t ^ e[38:35], e[37:34]};
      endcase
    end
  endfunction
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch = n_mismatch + 1;
    test_done;
  end
  // ==========
  // Scenarios.
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rd(`HPX_A_STATUS, d);
    chk("status reset", d, 32'h0);
    wr(`HPX_A_PROC_TAG, 32'hFFFF_FFFF);
    rd(`HPX_A_PROC_TAG, x);
    chk("process tag", x, 32'h000F_FFFF);
    for (i = 0; i < 15; i = i + 1) begin
      c = cases[8*i +: 8];
      flush;
      look(ea, {2'h0, c[5:3], c[6]}, c[1:0], 1'b1);
      chk("hit", d[1], 1'b1);
      chk("mix error", d[6], c[7]);
      rd(`HPX_A_SET_IDX, x);
      if (!c[7])
        chk("set index", x, hidx(ea, c[6], c[1:0]));
    end
    flush;
    look(ea2, 6'h0, 2'h0, 1'b1);
    rd(`HPX_A_VA_LO, x);
    chk("va low", x, {vs[3:0], ea2[27:0]});
    rd(`HPX_A_VA_MID, x);
    chk("va mid", x, vs[35:4]);
    rd(`HPX_A_RA_LO, x);
    chk("ra low", x, {rpn[19:0], ea2[11:0]});
    wr(`HPX_A_PTE, {3'h0, rpn, 2'h2});
    cmd(32'h1);
    chk("remap check", d[4], 1'b1);
    chk("machine check", mcheck, 1'b1);
    flush;
    repeat (2) @(posedge clock);
    chk("machine check", mcheck, 1'b0);
    look(ea2, 6'h0, 2'h2, 1'b0);
    chk("remap check", d[4], 1'b0);
    wr(`HPX_A_CORE_TUNE, 32'h0000_0100);
    flush;
    look(ea2, 6'h0, 2'h0, 1'b1);
    rd(`HPX_A_SET_IDX, x);
    c = hidx(ea2, 1'b0, 2'h0);
    chk("half index", x, {24'h0, 1'b0, c[6:0]});
    wr(`HPX_A_CORE_TUNE, 32'h0);
    flush;
    look(ea, 6'h0, 2'h0, 1'b1);
    for (i = 1; i < 31; i = i + 1) begin
      e2 = ea ^ ({32'h0, i} << 28);
      k = n_walk;
      look(e2, 6'h0, 2'h0, 1'b0);
      chk("walks", n_walk - k, 1);
      chk("searched tag", eff_segment_tag_seen, e2[63:28]);
      chk("hit", d[1], 1'b1);
    end
    k = n_walk;
    look(ea, 6'h0, 2'h0, 1'b0);
    chk("bolted walks", n_walk - k, 0);
    look(e2, 6'h0, 2'h0, 1'b0);
    chk("cached walks", n_walk - k, 0);
    tab_found = 1'b0;
    look(ea ^ 64'hF000_0000_0000_0000, 6'h0, 2'h0, 1'b0);
    chk("fault", d[2:1], 2'h2);
    tab_found = 1'b1;
    look(ea, 6'h0, 2'h0, 1'b0);
    wr(`HPX_A_STATUS, 32'h0000_03FE);
    cmd(32'h2);
    chk("find result", d[13:10], 4'h2);
    wr(`HPX_A_PART_CTL, 32'h1);
    wr(`HPX_A_STATUS, 32'h0000_03FE);
    cmd(32'h2);
    chk("find result", d[13:10], 4'h0);
    cmd(32'h1);
    chk("refused", d[7], 1'b1);
    wr(`HPX_A_PART_CTL, 32'h2);
    wr(`HPX_A_STATUS, 32'h0000_03FE);
    cmd(32'h1);
    chk("refused", d[7], 1'b1);
    wr(`HPX_A_PART_CTL, 32'h0);
    // A second bolted slot with the same segment tag as slot 0 must raise a multi-hit.
    wr(`HPX_A_STATUS, 32'h0000_03FE);
    look(ea, 6'h10, 2'h0, 1'b1);
    chk("multi hit", d[3], 1'b1);
    chk("machine check", mcheck, 1'b1);
    for (i = 0; i < 8; i = i + 1) begin
      cmd({25'h0, i[2:0], 4'h3});
      chk("hint", d[16:14], (i == 5) ? 3'h7 : i[2:0]);
      tlbi({24'h0, i[2:0], 3'h0, i[0], 1'b0}, i != 0 && i != 4 && i != 5);
    end
    tlbi(32'h0000_0D10, 1'b0);
    tlbi(32'h0000_0C10, 1'b1);
    // Switch to a radix partition and back, in the order system software must keep.
    tlbi(32'h0000_000E, 1'b0);
    tlbi(32'h0000_000E, 1'b0);
    wr(`HPX_A_PART_TAG, 32'h0000_0005);
    wr(`HPX_A_CORE_TUNE, 32'h0000_0100);
    wr(`HPX_A_PART_CTL, 32'h0000_0003);
    rd(`HPX_A_PART_CTL, x);
    chk("radix control", x, 32'h0000_0003);
    cmd(32'h1);
    chk("refused", d[7], 1'b1);
    wr(`HPX_A_PROC_TAG, 32'h0001_2345);
    rd(`HPX_A_PROC_TAG, x);
    chk("process tag", x, 32'h0001_2345);
    tlbi(32'h0000_000E, 1'b0);
    tlbi(32'h0000_000E, 1'b0);
    wr(`HPX_A_PART_TAG, 32'h0000_0006);
    wr(`HPX_A_CORE_TUNE, 32'h0);
    wr(`HPX_A_PART_CTL, 32'h0000_0014);
    rd(`HPX_A_PART_CTL, x);
    chk("hashed control", x, 32'h0000_0014);
    look(ea, 6'h0, 2'h0, 1'b1);
    chk("hit", d[1], 1'b1);
    test_done;
  end
endmodule // tb_hpx_xlate
